// [acs_defines.svh]
// Timing counts, mode codes and coefficient defaults of the calibration block
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH
`define ACS_CLK_HZ 100000000
`define ACS_MOD_DIV 256
`define ACS_RATE_DIV_DEFAULT 64
`define ACS_MODE_NORMAL 3'h0
`define ACS_MODE_SELF 3'h1
`define ACS_MODE_SYS_ZERO 3'h2
`define ACS_MODE_SYS_FULL 3'h3
`define ACS_MODE_SYS_OFFS 3'h4
`define ACS_MODE_BACKGND 3'h5
`define ACS_DUR_ONE_STEP 9
`define ACS_DUR_TWO_STEP 4
`define ACS_BG_FACTOR 6
`define ACS_OFFS_RESET 33'h000000000
`define ACS_GAIN_RESET 33'h080000000
`define ACS_GAIN_FRAC 31
`define ACS_REG_CMD 8'h00
`define ACS_REG_OFFS 8'h04
`define ACS_REG_GAIN 8'h08
`define ACS_REG_STAT 8'h0c
`define ACS_REG_RESULT 8'h10
`define ACS_REG_SYNC 8'h14
`endif

// [acs_pkg.sv]
// Types shared by the converter end and the host end
package acs_pkg;
    typedef enum logic [2:0] {
        ACS_ST_RUN = 3'b000,
        ACS_ST_ZERO = 3'b001,
        ACS_ST_FULL = 3'b010,
        ACS_ST_SETTLE = 3'b011,
        ACS_ST_BG = 3'b100
    } acs_state_t;
    typedef enum logic [1:0] {
        ACS_H_IDLE = 2'b00,
        ACS_H_SEND = 2'b01,
        ACS_H_WAIT = 2'b10
    } acs_hstate_t;
endpackage

// [acs_link_if.sv]
// Link between host controller and converter control logic
`timescale 1ns/1ps
interface acs_link_if;
    logic [2:0] cal_mode;
    logic cmd_strobe;
    logic coef_wr_offs;
    logic coef_wr_gain;
    logic [32:0] coef_wdata;
    logic sync_n;
    logic result_ready_n;
    logic [23:0] result;
    logic [32:0] offs_coef;
    logic [32:0] gain_coef;
    modport device (input cal_mode, cmd_strobe, coef_wr_offs, coef_wr_gain,
        coef_wdata, sync_n, output result_ready_n, result, offs_coef,
        gain_coef);
    modport host (output cal_mode, cmd_strobe, coef_wr_offs, coef_wr_gain,
        coef_wdata, sync_n, input result_ready_n, result, offs_coef,
        gain_coef);
endinterface

// [acs_device.sv]
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "acs_defines.svh"
module acs_device
    import acs_pkg::*;
#(
    parameter int RATE_DIV = `ACS_RATE_DIV_DEFAULT,
    parameter int RES_BITS = 24
) (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    acs_link_if.device LINK,
    input wire logic [23:0] RAW_SAMPLE,
    input wire logic [23:0] SHORT_SAMPLE,
    input wire logic [23:0] REF_SAMPLE,
    input wire logic BIPOLAR,
    input wire logic [2:0] GAIN_SEL,
    output logic [1:0] INPUT_SEL
);
    initial begin
        if (RES_BITS != 16 && RES_BITS != 24)
            $error("RES_BITS must be 16 or 24");
        if (RATE_DIV < 1 || RATE_DIV > 65535)
            $error("RATE_DIV out of range");
    end
    typedef struct packed {
        logic [7:0] mod_cnt;
        logic [15:0] rate_cnt;
        logic [3:0] step_cnt;
        logic [2:0] bg_cnt;
        acs_state_t st;
        logic [2:0] mode;
        logic sync_d;
        logic [32:0] offs;
        logic [32:0] gain;
        logic [32:0] zero_raw;
        logic [23:0] result;
        logic rdy_n;
        logic [1:0] in_sel;
    } acs_dev_t;
    acs_dev_t s_reg, s_next;
    logic mod_tick, out_tick, sync_fall;
    logic [32:0] diff, span;
    logic [65:0] prod;
    logic [23:0] res_cut;
    logic [32:0] full_val, zero_val;
    always_comb begin
        // Tick selection; every rate scales with CLK_SYS
        mod_tick = s_reg.mod_cnt == 8'(`ACS_MOD_DIV - 1);
        out_tick = mod_tick && s_reg.rate_cnt == 16'(RATE_DIV - 1);
        sync_fall = s_reg.sync_d && !LINK.sync_n;
        diff = {9'h000, RAW_SAMPLE} - s_reg.offs;
        prod = $signed(diff) * $signed({1'b0, s_reg.gain[31:0]});
        // Bipolar full span is midscale to full: double the half span
        span = BIPOLAR ? {s_reg.zero_raw[31:0], 1'b0} : s_reg.zero_raw;
        res_cut = prod[`ACS_GAIN_FRAC +: 24];
        if (RES_BITS == 16)
            res_cut = {res_cut[23:8], 8'h00};
        zero_val = (s_reg.st == ACS_ST_ZERO && s_reg.mode != `ACS_MODE_SYS_ZERO
            && s_reg.mode != `ACS_MODE_SYS_OFFS) ? {9'h000, SHORT_SAMPLE}
            : {9'h000, RAW_SAMPLE};
        // Reference conversion seen through the selected gain; raw input in system full mode
        full_val = (s_reg.mode == `ACS_MODE_SYS_FULL ? {9'h000, RAW_SAMPLE}
            : {9'h000, REF_SAMPLE} << GAIN_SEL) - s_reg.offs;
        s_next = s_reg;
        s_next.sync_d = LINK.sync_n;
        s_next.mod_cnt = mod_tick ? 8'h00 : s_reg.mod_cnt + 8'h01;
        if (mod_tick)
            s_next.rate_cnt = (s_reg.rate_cnt == 16'(RATE_DIV - 1)) ? 16'h0000
                : s_reg.rate_cnt + 16'h0001;
        if (LINK.coef_wr_offs)
            s_next.offs = LINK.coef_wdata;
        if (LINK.coef_wr_gain)
            s_next.gain = LINK.coef_wdata;
        if (out_tick) begin
            case (s_reg.st)
                ACS_ST_RUN: begin
                    s_next.result = res_cut;
                    s_next.rdy_n = 1'b0;
                end
                ACS_ST_ZERO: begin
                    if (s_reg.step_cnt != 4'h0)
                        s_next.step_cnt = s_reg.step_cnt - 4'h1;
                    else if (s_reg.mode == `ACS_MODE_SYS_ZERO) begin
                        s_next.offs = zero_val; // slope kept
                        s_next.st = ACS_ST_RUN;
                        s_next.rdy_n = 1'b0;
                    end else begin
                        s_next.offs = zero_val;
                        s_next.st = ACS_ST_FULL;
                        s_next.in_sel = 2'h2;
                        s_next.step_cnt = 4'h2;
                    end
                end
                ACS_ST_FULL: begin
                    if (s_reg.step_cnt != 4'h0)
                        s_next.step_cnt = s_reg.step_cnt - 4'h1;
                    else if (s_reg.mode == `ACS_MODE_SYS_FULL) begin
                        // Second system step ends the sequence at once
                        s_next.zero_raw = full_val;
                        s_next.gain = `ACS_GAIN_RESET;
                        s_next.st = ACS_ST_RUN;
                        s_next.rdy_n = 1'b0;
                    end else begin
                        s_next.zero_raw = full_val;
                        s_next.st = ACS_ST_SETTLE;
                        s_next.in_sel = 2'h0;
                        s_next.step_cnt = 4'h2;
                    end
                end
                ACS_ST_SETTLE: begin
                    // Gain reloaded with unity ACS_GAIN_RESET when span is nonzero; no division by span
                    if (s_reg.step_cnt == 4'h2 && span != 33'h0)
                        s_next.gain = `ACS_GAIN_RESET;
                    if (s_reg.step_cnt != 4'h0)
                        s_next.step_cnt = s_reg.step_cnt - 4'h1;
                    else begin
                        s_next.st = (s_reg.mode == `ACS_MODE_BACKGND)
                            ? ACS_ST_BG : ACS_ST_RUN;
                        // Background keeps ready high until its first result
                        s_next.rdy_n = s_reg.mode == `ACS_MODE_BACKGND;
                    end
                end
                ACS_ST_BG: begin
                    // One result per six output periods
                    s_next.bg_cnt = (s_reg.bg_cnt == 3'(`ACS_BG_FACTOR - 1))
                        ? 3'h0 : s_reg.bg_cnt + 3'h1;
                    if (s_reg.bg_cnt == 3'h0) begin
                        s_next.result = res_cut;
                        s_next.rdy_n = 1'b0;
                    end else if (s_reg.bg_cnt == 3'h2)
                        s_next.offs = {9'h000, SHORT_SAMPLE};
                end
                default: s_next.st = ACS_ST_RUN;
            endcase
        end
        // Filter restart on sync edge
        if (sync_fall) begin
            s_next.mod_cnt = 8'h00;
            s_next.rate_cnt = 16'h0000;
            s_next.bg_cnt = 3'h0;
        end
        if (LINK.cmd_strobe) begin
            s_next.mode = LINK.cal_mode;
            s_next.mod_cnt = 8'h00;
            s_next.rate_cnt = 16'h0000;
            s_next.bg_cnt = 3'h0;
            s_next.rdy_n = (LINK.cal_mode == `ACS_MODE_NORMAL)
                ? s_reg.rdy_n : 1'b1;
            s_next.in_sel = (LINK.cal_mode == `ACS_MODE_SELF ||
                LINK.cal_mode == `ACS_MODE_BACKGND) ? 2'h1 : 2'h0;
            case (LINK.cal_mode)
                `ACS_MODE_SELF, `ACS_MODE_SYS_OFFS: begin
                    s_next.st = ACS_ST_ZERO;
                    s_next.step_cnt = 4'h2;
                end
                `ACS_MODE_SYS_ZERO: begin
                    s_next.st = ACS_ST_ZERO;
                    s_next.step_cnt = 4'(`ACS_DUR_TWO_STEP - 1);
                end
                `ACS_MODE_SYS_FULL: begin
                    s_next.st = ACS_ST_FULL;
                    s_next.step_cnt = 4'(`ACS_DUR_TWO_STEP - 1);
                end
                `ACS_MODE_BACKGND: begin
                    s_next.st = ACS_ST_ZERO;
                    s_next.step_cnt = 4'h0;
                end
                default: s_next.st = ACS_ST_RUN;
            endcase
        end
        if (s_next.st != ACS_ST_RUN && s_next.st != ACS_ST_BG)
            s_next.rdy_n = 1'b1;
    end
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            s_reg <= '0;
            s_reg.sync_d <= 1'b1;
            s_reg.rdy_n <= 1'b1;
            s_reg.gain <= `ACS_GAIN_RESET;
        end else begin
            s_reg <= s_next;
        end
    end
    assign LINK.result_ready_n = s_reg.rdy_n;
    assign LINK.result = s_reg.result;
    assign LINK.offs_coef = s_reg.offs;
    assign LINK.gain_coef = s_reg.gain;
    assign INPUT_SEL = s_reg.in_sel;
    logic unused_ok;
    assign unused_ok = ^{prod[65:55], prod[30:0]};
endmodule // acs_device

// [acs_host.sv]
// Host controller: APB register slave driving the converter link
`timescale 1ns/1ps
`include "acs_defines.svh"
module acs_host
    import acs_pkg::*;
#(
    parameter int MOD_DIV = `ACS_MOD_DIV
) (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    acs_link_if.host LINK,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);
    initial begin
        if (MOD_DIV < 1 || MOD_DIV > 65535)
            $error("MOD_DIV out of range");
    end
    typedef struct packed {
        acs_hstate_t st;
        logic [15:0] blank;
        logic [2:0] mode;
        logic stb;
        logic wr_o;
        logic wr_g;
        logic [32:0] wdata;
        logic sync_n;
        logic done;
        logic [31:0] rdata;
        logic ready;
        logic err;
    } acs_host_t;
    acs_host_t h_reg, h_next;
    logic acc;
    always_comb begin
        acc = PSEL && PENABLE && !h_reg.ready;
        h_next = h_reg;
        h_next.stb = 1'b0;
        h_next.wr_o = 1'b0;
        h_next.wr_g = 1'b0;
        h_next.ready = acc;
        h_next.err = 1'b0;
        h_next.rdata = 32'h00000000;
        if (acc && PWRITE) begin
            case (PADDR)
                `ACS_REG_CMD: begin
                    h_next.mode = PWDATA[2:0];
                    h_next.stb = 1'b1;
                    h_next.done = 1'b0;
                    h_next.st = ACS_H_WAIT;
                    h_next.blank = 16'(MOD_DIV);
                end
                `ACS_REG_OFFS: begin
                    h_next.wdata = {1'b0, PWDATA};
                    h_next.wr_o = 1'b1;
                end
                `ACS_REG_GAIN: begin
                    h_next.wdata = {1'b0, PWDATA};
                    h_next.wr_g = 1'b1;
                end
                // Sync line is the written bit inverted; software sets and clears it
                `ACS_REG_SYNC: h_next.sync_n = ~PWDATA[0];
                default: h_next.err = 1'b1;
            endcase
        end else if (acc) begin
            case (PADDR)
                `ACS_REG_CMD: h_next.rdata = {29'h0, h_reg.mode};
                `ACS_REG_OFFS: h_next.rdata = LINK.offs_coef[31:0];
                `ACS_REG_GAIN: h_next.rdata = LINK.gain_coef[31:0];
                `ACS_REG_STAT: h_next.rdata = {30'h0, h_reg.done,
                    LINK.result_ready_n};
                `ACS_REG_RESULT: h_next.rdata = {8'h00, LINK.result};
                `ACS_REG_SYNC: h_next.rdata = {31'h0, ~h_reg.sync_n};
                default: h_next.err = 1'b1;
            endcase
        end
        // A new command wins over completion of the previous one
        if (!h_next.stb) case (h_reg.st)
            ACS_H_WAIT: begin
                // Ready is stale until the blanking window ends
                if (h_reg.blank != 16'h0000)
                    h_next.blank = h_reg.blank - 16'h0001;
                else if (!LINK.result_ready_n) begin
                    h_next.done = 1'b1;
                    h_next.st = ACS_H_IDLE;
                end
            end
            ACS_H_IDLE, ACS_H_SEND: ;
            default: h_next.st = ACS_H_IDLE;
        endcase
    end
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            h_reg <= '0;
            h_reg.sync_n <= 1'b1;
        end else begin
            h_reg <= h_next;
        end
    end
    assign LINK.cal_mode = h_reg.mode;
    assign LINK.cmd_strobe = h_reg.stb;
    assign LINK.coef_wr_offs = h_reg.wr_o;
    assign LINK.coef_wr_gain = h_reg.wr_g;
    assign LINK.coef_wdata = h_reg.wdata;
    assign LINK.sync_n = h_reg.sync_n;
    assign PRDATA = h_reg.rdata;
    assign PREADY = h_reg.ready;
    assign PSLVERR = h_reg.err;
endmodule // acs_host

// [acs_link_properties.sv]
// Concurrent checks on the link between host controller and converter
`timescale 1ns/1ps
`include "acs_defines.svh"
module acs_link_properties #(
    parameter int PERIOD = 256
) (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic [2:0] cal_mode,
    input wire logic cmd_strobe,
    input wire logic coef_wr_offs,
    input wire logic coef_wr_gain,
    input wire logic [32:0] coef_wdata,
    input wire logic sync_n,
    input wire logic result_ready_n,
    input wire logic [23:0] result,
    input wire logic [32:0] offs_coef,
    input wire logic [32:0] gain_coef
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    logic [15:0] cyc_reg;
    logic [32:0] gain_hold_reg;
    // Cycles since the last command, and the slope seen when it was issued
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            cyc_reg <= 16'h0;
            gain_hold_reg <= 33'h0;
        end else if (cmd_strobe) begin
            cyc_reg <= 16'h0;
            gain_hold_reg <= gain_coef;
        end else if (cyc_reg != 16'hffff) begin
            cyc_reg <= cyc_reg + 16'h1;
        end
    end
    property p_busy_on_cmd;
        cmd_strobe && cal_mode != `ACS_MODE_NORMAL |=> result_ready_n;
    endproperty
    a_busy_on_cmd: assert property (p_busy_on_cmd)
        else $error("ready not raised after calibration command");
    property p_busy_hold;
        cmd_strobe && cal_mode inside {`ACS_MODE_SELF, `ACS_MODE_SYS_OFFS}
            |=> result_ready_n [*8];
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("ready dropped early in calibration");
    property p_result_frozen;
        cmd_strobe && cal_mode != `ACS_MODE_NORMAL |=> $stable(result) [*8];
    endproperty
    a_result_frozen: assert property (p_result_frozen)
        else $error("result changed during calibration");
    property p_offs_load;
        coef_wr_offs |=> offs_coef == $past(coef_wdata);
    endproperty
    a_offs_load: assert property (p_offs_load)
        else $error("offset coefficient not loaded");
    property p_gain_load;
        coef_wr_gain |=> gain_coef == $past(coef_wdata);
    endproperty
    a_gain_load: assert property (p_gain_load)
        else $error("gain coefficient not loaded");
    property p_slope_kept;
        $fell(result_ready_n) && cal_mode == `ACS_MODE_SYS_ZERO
            |-> gain_coef == gain_hold_reg;
    endproperty
    a_slope_kept: assert property (p_slope_kept)
        else $error("zero step changed the slope");
    property p_two_step_time;
        $fell(result_ready_n) && cal_mode inside {`ACS_MODE_SYS_ZERO,
            `ACS_MODE_SYS_FULL} |-> cyc_reg >= 4 * PERIOD - 2
            && cyc_reg <= 5 * PERIOD;
    endproperty
    a_two_step_time: assert property (p_two_step_time)
        else $error("system step duration wrong");
    property p_one_step_time;
        $fell(result_ready_n) && cal_mode inside {`ACS_MODE_SELF,
            `ACS_MODE_SYS_OFFS} |-> cyc_reg >= 9 * PERIOD - 2
            && cyc_reg <= 10 * PERIOD;
    endproperty
    a_one_step_time: assert property (p_one_step_time)
        else $error("one step calibration duration wrong");
    property p_unity_after_full;
        $fell(result_ready_n) && cal_mode == `ACS_MODE_SYS_FULL
            |-> gain_coef == `ACS_GAIN_RESET;
    endproperty
    a_unity_after_full: assert property (p_unity_after_full)
        else $error("gain not reloaded after full step");
    property p_sync_quiet;
        $fell(sync_n) |=> $stable(result) [*8];
    endproperty
    a_sync_quiet: assert property (p_sync_quiet)
        else $error("result changed right after sync");
    c_self_done: cover property ($fell(result_ready_n)
        && cal_mode == `ACS_MODE_SELF);
    c_sync: cover property ($fell(sync_n));
    c_offs_write: cover property (coef_wr_offs);
endmodule // acs_link_properties

// [adc_calibration_sequencer_tb_top.sv]
// Self-checking bench for the host controller and converter pair
`timescale 1ns/1ps
`include "acs_defines.svh"
`define ACS_CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
    err_total++; $display("unexpected at %0t: got %h want %h", $time, \
    g, e); end end
module adc_calibration_sequencer_tb_top;
    localparam int P = 256;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, rerr;
    logic [23:0] raw = 24'h001000;
    logic [1:0] input_sel;
    logic saw_short = 1'b0, saw_order = 1'b0, saw_sync = 1'b0;
    int err_total = 0, check_count = 0, cyc = 0, n;
    acs_link_if link();
    acs_device #(.RATE_DIV(1)) u_acs_device (.CLK_SYS(clk_sys),
        .RSTN(rstn), .LINK(link), .RAW_SAMPLE(raw),
        .SHORT_SAMPLE(24'h000008), .REF_SAMPLE(24'h7ffff0),
        .BIPOLAR(1'b0), .GAIN_SEL(3'h0), .INPUT_SEL(input_sel));
    acs_host u_acs_host (.CLK_SYS(clk_sys), .RSTN(rstn), .LINK(link),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr));
    acs_link_properties #(.PERIOD(P)) u_acs_link_properties (
        .CLK_SYS(clk_sys), .RSTN(rstn), .cal_mode(link.cal_mode),
        .cmd_strobe(link.cmd_strobe), .coef_wr_offs(link.coef_wr_offs),
        .coef_wr_gain(link.coef_wr_gain), .coef_wdata(link.coef_wdata),
        .sync_n(link.sync_n), .result_ready_n(link.result_ready_n),
        .result(link.result), .offs_coef(link.offs_coef),
        .gain_coef(link.gain_coef));
    always #5 clk_sys = ~clk_sys;
    // Watch the input selector and sync line while calibrations run
    always @(posedge clk_sys) begin
        cyc++;
        if (input_sel == 2'd1) saw_short <= 1'b1;
        if (input_sel == 2'd2 && saw_short) saw_order <= 1'b1;
        if (link.sync_n === 1'b0) saw_sync <= 1'b1;
        if (cyc == 30000) begin
            err_total++;
            $display("unexpected at %0t: run timed out", $time);
            final_report();
        end
    end
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Slave latency is the design's own; wait for its answer
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            err_total++;
            $display("unexpected at %0t: bus answer missing", $time);
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    // Poll the done flag; returns cycles spent since the command
    task automatic cmd_wait(input logic [2:0] m, output int t);
        int t0;
        wr(`ACS_REG_CMD, {29'h0, m});
        t0 = cyc;
        rdat = 32'h0;
        while (rdat[1] !== 1'b1 && cyc - t0 < 4000) rd(`ACS_REG_STAT);
        t = cyc - t0;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(`ACS_REG_OFFS);
        `ACS_CHK(rdat, 32'h0)
        rd(`ACS_REG_GAIN);
        `ACS_CHK(rdat, 32'h80000000)
        rd(`ACS_REG_STAT);
        `ACS_CHK(rdat[0], 1'b1)
        rd(8'h20);
        `ACS_CHK(rerr, 1'b1)
        $display("test reset done");
        wr(`ACS_REG_OFFS, 32'h10);
        wr(`ACS_REG_GAIN, 32'h40000000);
        rd(`ACS_REG_OFFS);
        `ACS_CHK(rdat, 32'h10)
        repeat (3 * P) @(posedge clk_sys);
        rd(`ACS_REG_RESULT);
        // Offset comes off first, then the half gain scales it
        `ACS_CHK(rdat[23:0], 24'h0007f8)
        $display("test arithmetic done");
        cmd_wait(`ACS_MODE_SYS_ZERO, n);
        `ACS_CHK(n >= 4 * P - 8 && n <= 5 * P + 16, 1'b1)
        rd(`ACS_REG_GAIN);
        `ACS_CHK(rdat, 32'h40000000)
        cmd_wait(`ACS_MODE_SYS_FULL, n);
        `ACS_CHK(n >= 4 * P - 8 && n <= 5 * P + 16, 1'b1)
        rd(`ACS_REG_GAIN);
        `ACS_CHK(rdat, 32'h80000000)
        $display("test system calibration done");
        saw_short = 1'b0;
        saw_order = 1'b0;
        cmd_wait(`ACS_MODE_SELF, n);
        `ACS_CHK(n >= 9 * P - 8 && n <= 10 * P + 16, 1'b1)
        `ACS_CHK(saw_order, 1'b1)
        `ACS_CHK(input_sel, 2'd0)
        cmd_wait(`ACS_MODE_SYS_OFFS, n);
        `ACS_CHK(n >= 9 * P - 8 && n <= 10 * P + 16, 1'b1)
        $display("test one step calibration done");
        wr(`ACS_REG_CMD, {29'h0, `ACS_MODE_BACKGND});
        rd(`ACS_REG_STAT);
        `ACS_CHK(rdat[0], 1'b1)
        repeat (2 * P) @(posedge clk_sys);
        wr(`ACS_REG_CMD, {29'h0, `ACS_MODE_NORMAL});
        $display("test background done");
        wr(`ACS_REG_SYNC, 32'h1);
        wr(`ACS_REG_SYNC, 32'h0);
        `ACS_CHK(saw_sync, 1'b1)
        `ACS_CHK(link.sync_n, 1'b1)
        $display("test sync done");
        final_report();
    end
endmodule // adc_calibration_sequencer_tb_top
